//--- afemc_top.v
`timescale 1ns/10ps
`include "afemc_defines.vh"

module afemc_top
(
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [2:0]  addr_strap,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_drive_n,
  input  wire        adc_done,
  input  wire [15:0] adc_data,
  output wire        adc_start,
  output wire [1:0]  adc_source,
  output wire        ladder_to_tia_switch,
  output wire        ladder_to_potentiostat_switch,
  output wire        tia_sensor_input_select,
  output wire        potentiostat_sensor_input_select,
  output wire        onward_signal_select,
  output wire        preamp_enable,
  output wire [2:0]  tia_bias_level,
  output wire [4:0]  potentiostat_bias_level,
  output wire        bias_ladder_power,
  output wire [7:0]  block_power_enable
);

  // ========================================================
  // Two-wire slave states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_RECV = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_SEND = 7'h20;
  localparam [6:0] ST_SACK = 7'h40;

  // Offset match, shared by write decode and read mux
  function is_ofs;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_ofs = (addr == ofs);
    end
  endfunction

  reg  [6:0]  state_q;
  reg         scl_q;
  reg         sda_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  tx_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  ptr_q;
  reg         ptr_phase_q;
  reg         rw_q;
  reg         master_ack_q;
  reg         wr_stb_q;
  reg  [7:0]  wr_addr_q;
  reg  [7:0]  wr_data_q;
  reg  [2:0]  ctrl_q;
  reg  [7:0]  ladder_sw_q;
  reg  [7:0]  bias_level_q;
  reg  [7:0]  io_routing_q;
  reg  [7:0]  power_en_q;
  reg  [7:0]  rd_byte;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  wire        start_req;
  wire        stop_req;
  wire        busy;
  wire [15:0] amp_res;
  wire [9:0]  temp_res;
  wire [6:0]  my_addr;

  assign my_addr   = {`AFEMC_ADDR_BASE, addr_strap};
  assign sda_out   = 1'b0;
  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
  assign bus_stop  = scl_in & scl_q & ~sda_q & sda_in;

  // ========================================================
  // Line history for edge and condition detection
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ========================================================
  // Two-wire byte engine with auto-incrementing register pointer
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q      <= ST_IDLE;
      shift_q      <= 8'h00;
      tx_q         <= 8'h00;
      bit_cnt_q    <= 4'h0;
      ptr_q        <= 8'h00;
      ptr_phase_q  <= 1'b0;
      rw_q         <= 1'b0;
      master_ack_q <= 1'b0;
      sda_drive_n  <= 1'b1;
      wr_stb_q     <= 1'b0;
      wr_addr_q    <= 8'h00;
      wr_data_q    <= 8'h00;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      if (bus_start)
      begin
        state_q     <= ST_ADDR;
        bit_cnt_q   <= 4'h0;
        ptr_phase_q <= 1'b1;
        sda_drive_n <= 1'b1;
      end
      else if (bus_stop)
      begin
        state_q     <= ST_IDLE;
        sda_drive_n <= 1'b1;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            sda_drive_n <= 1'b1;
          end
          ST_ADDR:
          begin
            if (scl_rise)
            begin
              shift_q   <= {shift_q[6:0], sda_in};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              if (shift_q[7:1] == my_addr)
              begin
                rw_q        <= shift_q[0];
                sda_drive_n <= 1'b0;
                state_q     <= ST_AACK;
              end
              else
                state_q <= ST_IDLE;
            end
          end
          ST_AACK:
          begin
            if (scl_fall)
            begin
              bit_cnt_q <= 4'h0;
              if (rw_q)
              begin
                tx_q        <= rd_byte;
                sda_drive_n <= rd_byte[7];
                state_q     <= ST_SEND;
              end
              else
              begin
                sda_drive_n <= 1'b1;
                state_q     <= ST_RECV;
              end
            end
          end
          ST_RECV:
          begin
            if (scl_rise)
            begin
              shift_q   <= {shift_q[6:0], sda_in};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              sda_drive_n <= 1'b0;
              state_q     <= ST_RACK;
              if (ptr_phase_q)
              begin
                ptr_q       <= shift_q;
                ptr_phase_q <= 1'b0;
              end
              else
              begin
                wr_stb_q  <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q     <= ptr_q + 8'h01;
              end
            end
          end
          ST_RACK:
          begin
            if (scl_fall)
            begin
              sda_drive_n <= 1'b1;
              bit_cnt_q   <= 4'h0;
              state_q     <= ST_RECV;
            end
          end
          ST_SEND:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_q == 4'h7)
              begin
                sda_drive_n <= 1'b1;
                ptr_q       <= ptr_q + 8'h01;
                state_q     <= ST_SACK;
              end
              else
              begin
                tx_q        <= {tx_q[6:0], 1'b0};
                sda_drive_n <= tx_q[6];
                bit_cnt_q   <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_SACK:
          begin
            if (scl_rise)
              master_ack_q <= ~sda_in;
            else if (scl_fall)
            begin
              // A missing acknowledge ends the read burst
              if (master_ack_q)
              begin
                tx_q        <= rd_byte;
                sda_drive_n <= rd_byte[7];
                bit_cnt_q   <= 4'h0;
                state_q     <= ST_SEND;
              end
              else
                state_q <= ST_IDLE;
            end
          end
          default:
          begin
            state_q     <= ST_IDLE;
            sda_drive_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ========================================================
  // Software registers
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q       <= 3'h0;
      ladder_sw_q  <= `AFEMC_RST_BYTE;
      bias_level_q <= `AFEMC_RST_BYTE;
      io_routing_q <= `AFEMC_RST_BYTE;
      power_en_q   <= `AFEMC_RST_BYTE;
    end
    else if (wr_stb_q)
    begin
      if (is_ofs(wr_addr_q, `AFEMC_OFS_CONVERSION_BUSY_CTRL))
        ctrl_q <= wr_data_q[`AFEMC_SRC_HI:`AFEMC_MODE_BIT];
      if (is_ofs(wr_addr_q, `AFEMC_OFS_LADDER_SW))
        ladder_sw_q <= wr_data_q;
      if (is_ofs(wr_addr_q, `AFEMC_OFS_BIAS_LEVEL))
        bias_level_q <= wr_data_q;
      if (is_ofs(wr_addr_q, `AFEMC_OFS_IO_ROUTING))
        io_routing_q <= wr_data_q;
      if (is_ofs(wr_addr_q, `AFEMC_OFS_POWER_EN))
        power_en_q <= wr_data_q;
    end
  end

  // Start or stop on a control write; the start takes the new mode and source
  assign start_req = wr_stb_q & is_ofs(wr_addr_q, `AFEMC_OFS_CONVERSION_BUSY_CTRL) &
                     wr_data_q[`AFEMC_BUSY_BIT];
  assign stop_req  = wr_stb_q & is_ofs(wr_addr_q, `AFEMC_OFS_CONVERSION_BUSY_CTRL) &
                     ~wr_data_q[`AFEMC_BUSY_BIT];

  // ========================================================
  // Read mux; unmapped offsets read zero
  always @*
  begin
    rd_byte = 8'h00;
    if (is_ofs(ptr_q, `AFEMC_OFS_CONVERSION_BUSY_CTRL))
      rd_byte = {4'h0, busy, ctrl_q};
    else if (is_ofs(ptr_q, `AFEMC_OFS_AMP_LOW))
      rd_byte = amp_res[7:0];
    else if (is_ofs(ptr_q, `AFEMC_OFS_AMP_HIGH))
      rd_byte = amp_res[15:8];
    else if (is_ofs(ptr_q, `AFEMC_OFS_TEMP_LOW))
      rd_byte = temp_res[7:0];
    else if (is_ofs(ptr_q, `AFEMC_OFS_TEMP_HIGH))
      rd_byte = {6'h00, temp_res[9:8]};
    else if (is_ofs(ptr_q, `AFEMC_OFS_LADDER_SW))
      rd_byte = ladder_sw_q;
    else if (is_ofs(ptr_q, `AFEMC_OFS_BIAS_LEVEL))
      rd_byte = bias_level_q;
    else if (is_ofs(ptr_q, `AFEMC_OFS_IO_ROUTING))
      rd_byte = io_routing_q;
    else if (is_ofs(ptr_q, `AFEMC_OFS_POWER_EN))
      rd_byte = power_en_q;
  end

  // ========================================================
  // Analog control outputs straight from register bits
  assign ladder_to_tia_switch             = ladder_sw_q[`AFEMC_LADDER_TIA_BIT];
  assign ladder_to_potentiostat_switch    = ladder_sw_q[`AFEMC_LADDER_POT_BIT];
  assign tia_sensor_input_select          = io_routing_q[`AFEMC_TIA_SENSOR_BIT];
  assign potentiostat_sensor_input_select = io_routing_q[`AFEMC_POT_SENSOR_BIT];
  assign onward_signal_select             = io_routing_q[`AFEMC_ONWARD_BIT];
  assign preamp_enable                    = io_routing_q[`AFEMC_PREAMP_BIT];
  assign tia_bias_level    = bias_level_q[`AFEMC_TIA_BIAS_HI:`AFEMC_TIA_BIAS_LO];
  assign potentiostat_bias_level = bias_level_q[`AFEMC_POT_BIAS_HI:`AFEMC_POT_BIAS_LO];
  assign block_power_enable = power_en_q;
  assign bias_ladder_power  = power_en_q[7];

  // ========================================================
  // Conversion sequencer
  afemc_conv_seq u_seq
  (
    .clock                  (clock),
    .sys_rst                (sys_rst),
    .start_req              (start_req),
    .stop_req               (stop_req),
    .conversion_mode_select (wr_data_q[`AFEMC_MODE_BIT]),
    .input_source_select    (wr_data_q[`AFEMC_SRC_HI:`AFEMC_SRC_LO]),
    .adc_done               (adc_done),
    .adc_data               (adc_data),
    .adc_start              (adc_start),
    .adc_source             (adc_source),
    .conversion_busy        (busy),
    .amplifier_result       (amp_res),
    .temperature_result     (temp_res)
  );

endmodule // afemc_top

//--- afemc_defines.vh
`ifndef AFEMC_DEFINES_VH
`define AFEMC_DEFINES_VH

// ==========================================================
// Register offsets
`define AFEMC_OFS_CONVERSION_BUSY_CTRL    8'h00
`define AFEMC_OFS_AMP_LOW      8'h02
`define AFEMC_OFS_AMP_HIGH     8'h03
`define AFEMC_OFS_TEMP_LOW     8'h06
`define AFEMC_OFS_TEMP_HIGH    8'h07
`define AFEMC_OFS_LADDER_SW    8'h0f
`define AFEMC_OFS_BIAS_LEVEL   8'h10
`define AFEMC_OFS_IO_ROUTING   8'h11
`define AFEMC_OFS_POWER_EN     8'h12

// ==========================================================
// Field positions
`define AFEMC_MODE_BIT         0
`define AFEMC_SRC_HI           2
`define AFEMC_SRC_LO           1
`define AFEMC_BUSY_BIT         3
`define AFEMC_LADDER_TIA_BIT   5
`define AFEMC_LADDER_POT_BIT   4
`define AFEMC_TIA_SENSOR_BIT   6
`define AFEMC_POT_SENSOR_BIT   5
`define AFEMC_ONWARD_BIT       3
`define AFEMC_PREAMP_BIT       2
`define AFEMC_TIA_BIAS_HI      7
`define AFEMC_TIA_BIAS_LO      5
`define AFEMC_POT_BIAS_HI      4
`define AFEMC_POT_BIAS_LO      0

// ==========================================================
// Input source codes and reset values
`define AFEMC_SRC_TEMP         2'h0
`define AFEMC_SRC_AMP          2'h1
`define AFEMC_RST_BYTE         8'h00

// ==========================================================
// Two-wire address: base bits above the three strap bits (value arbitrary)
`define AFEMC_ADDR_BASE        4'h9

`endif

//--- afemc_conv_seq.v
`timescale 1ns/10ps
`include "afemc_defines.vh"

module afemc_conv_seq
(
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        start_req,
  input  wire        stop_req,
  input  wire        conversion_mode_select,
  input  wire [1:0]  input_source_select,
  input  wire        adc_done,
  input  wire [15:0] adc_data,
  output reg         adc_start,
  output reg  [1:0]  adc_source,
  output wire        conversion_busy,
  output reg  [15:0] amplifier_result,
  output reg  [9:0]  temperature_result
);

  // ========================================================
  // Sequencer states
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_LAUNCH = 3'h2;
  localparam [2:0] ST_WAIT   = 3'h4;

  reg  [2:0] state_q;
  reg        run_on_q;
  wire       src_ok;

  // Only temperature and amplifier path are converted here
  assign src_ok = (input_source_select == `AFEMC_SRC_TEMP) ||
                  (input_source_select == `AFEMC_SRC_AMP);

  assign conversion_busy = ~state_q[0];

  // ========================================================
  // Launch, wait for the converter, capture, restart or stop
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q            <= ST_IDLE;
      run_on_q           <= 1'b0;
      adc_start          <= 1'b0;
      adc_source         <= 2'h0;
      amplifier_result   <= 16'h0000;
      temperature_result <= 10'h000;
    end
    else
    begin
      adc_start <= 1'b0;
      if (stop_req)
        run_on_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start_req && src_ok)
          begin
            adc_source <= input_source_select;
            run_on_q   <= conversion_mode_select;
            state_q    <= ST_LAUNCH;
          end
        end
        ST_LAUNCH:
        begin
          adc_start <= 1'b1;
          state_q   <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (adc_done)
          begin
            if (adc_source == `AFEMC_SRC_TEMP)
              temperature_result <= adc_data[15:6];
            else
              amplifier_result <= adc_data;
            // Single mode ends here; continuous relaunches until stopped
            if (run_on_q && !stop_req)
              state_q <= ST_LAUNCH;
            else
              state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // afemc_conv_seq

//--- afemc_top_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker of the measurement block
module afemc_top_asserts
(
  input wire        clock,
  input wire        sys_rst,
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_drive_n,
  input wire        adc_done,
  input wire        adc_start,
  input wire [1:0]  adc_source,
  input wire        ladder_to_tia_switch,
  input wire        ladder_to_potentiostat_switch,
  input wire        tia_sensor_input_select,
  input wire        potentiostat_sensor_input_select,
  input wire        onward_signal_select,
  input wire        preamp_enable,
  input wire [2:0]  tia_bias_level,
  input wire [4:0]  potentiostat_bias_level,
  input wire        bias_ladder_power,
  input wire [7:0]  block_power_enable
);
  // Routing, bias and power outputs gathered in one word
  wire [21:0] cfg_word = {ladder_to_tia_switch, ladder_to_potentiostat_switch,
    tia_sensor_input_select, potentiostat_sensor_input_select, onward_signal_select,
    preamp_enable, tia_bias_level, potentiostat_bias_level, block_power_enable};

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Properties
  a_reset_quiet: assert property ($fell(sys_rst) |->
    sda_drive_n && !adc_start && adc_source == 2'h0 && cfg_word == 22'h000000)
    else $error("outputs not idle after reset");
  a_start_single: assert property (adc_start |=> !adc_start)
    else $error("launch pulse longer than one cycle");
  a_source_legal: assert property (adc_start |-> adc_source[1] == 1'b0)
    else $error("launch with unsupported source");
  a_source_held: assert property (adc_start |=> $stable(adc_source) [*3])
    else $error("source moved during conversion");
  a_start_cause: assert property (adc_start |->
    $past(sda_drive_n, 2) == 1'b0 || $past(adc_done, 2))
    else $error("launch without a register write");
  a_done_no_start: assert property (adc_done |=> !adc_start)
    else $error("relaunch right after completion");
  a_drive_open: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_drive_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_drive_n))
    else $error("data drive changed while clock high");
  a_power_ladder: assert property (bias_ladder_power == block_power_enable[7])
    else $error("ladder power differs from enable bit 7");
  a_cfg_by_bus: assert property ($changed(cfg_word) |->
    $past(sda_drive_n) == 1'b0)
    else $error("configuration changed without a write");
endmodule // afemc_top_asserts

bind afemc_top afemc_top_asserts u_chk
(
  .clock, .sys_rst, .scl_in, .sda_out, .sda_drive_n, .adc_done, .adc_start, .adc_source,
  .ladder_to_tia_switch, .ladder_to_potentiostat_switch, .tia_sensor_input_select,
  .potentiostat_sensor_input_select, .onward_signal_select, .preamp_enable,
  .tia_bias_level, .potentiostat_bias_level, .bias_ladder_power, .block_power_enable
);

//--- afemc_top_tb_top.sv
`timescale 1ns/10ps
`include "afemc_defines.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module afemc_top_tb_top;
  // ==========================================================
  // Signals
  reg         clock = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [2:0]  addr_strap = 3'h5;
  reg         scl_in = 1'b1;
  reg         sda_host = 1'b1;
  reg         adc_done = 1'b0;
  reg  [15:0] adc_data = 16'h0000;
  wire        sda_in, sda_out, sda_drive_n, adc_start, bias_ladder_power;
  wire [1:0]  adc_source;
  wire        ladder_to_tia_switch, ladder_to_potentiostat_switch, preamp_enable;
  wire        tia_sensor_input_select, potentiostat_sensor_input_select, onward_signal_select;
  wire [2:0]  tia_bias_level;
  wire [4:0]  potentiostat_bias_level;
  wire [7:0]  block_power_enable;
  wire [6:0]  dev_addr = {`AFEMC_ADDR_BASE, addr_strap};
  int         err_total = 0;
  int         checked = 0;
  int         n_starts = 0;
  int         lat = 10;
  int         cnt = -1;
  int         k;
  int         n;
  reg  [15:0] lfsr = 16'ha006;
  reg  [15:0] conv_val = 16'h0000;
  reg  [1:0]  conv_src = 2'h0;
  reg  [31:0] v;
  reg  [7:0]  j;
  reg  [7:0]  q;

  always #2.5 clock = ~clock;
  // Open-drain data wire with pull-up
  assign sda_in = sda_host & (sda_drive_n | sda_out);

  afemc_top DUT
  (
    .clock, .sys_rst, .addr_strap, .scl_in, .sda_in, .sda_out, .sda_drive_n, .adc_done,
    .adc_data, .adc_start, .adc_source, .ladder_to_tia_switch, .ladder_to_potentiostat_switch,
    .tia_sensor_input_select, .potentiostat_sensor_input_select, .onward_signal_select,
    .preamp_enable, .tia_bias_level, .potentiostat_bias_level, .bias_ladder_power,
    .block_power_enable
  );

  // ==========================================================
  // Helper functions
  function [15:0] lfsr_next(input [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function [15:0] exp_pair(input [1:0] src, input [15:0] raw);
    exp_pair = src[0] ? raw : {6'h00, raw[15:6]};
  endfunction

  // Converter stand-in: answers each launch lat+1 cycles after the edge that samples it
  always @(posedge clock)
  begin
    adc_done <= 1'b0;
    if (adc_start === 1'b1)
    begin
      cnt = lat;
      n_starts++;
      conv_src = adc_source;
    end
    else if (cnt > 0)
      cnt = cnt - 1;
    else if (cnt == 0)
    begin
      cnt = -1;
      conv_val = lfsr_next(conv_val ^ 16'h5a5a);
      adc_data <= conv_val;
      adc_done <= 1'b1;
    end
  end

  // ==========================================================
  // Two-wire host tasks
  task cyc(input int c);
    repeat (c) @(posedge clock);
  endtask

  // Start when s is 1, stop when s is 0
  task cond(input reg s);
  begin
    @(posedge clock) sda_host <= s;
    cyc(2);
    @(posedge clock) scl_in <= 1'b1;
    cyc(3);
    @(posedge clock) sda_host <= ~s;
    cyc(3);
    if (s)
      @(posedge clock) scl_in <= 1'b0;
  end
  endtask

  // One bit: low phase 5 cycles, high phase 3, sampled mid-high
  task bit_io(input reg b, output reg r);
  begin
    @(posedge clock) sda_host <= b;
    cyc(3);
    @(posedge clock) scl_in <= 1'b1;
    cyc(2);
    #1 r = sda_in;
    @(posedge clock) scl_in <= 1'b0;
  end
  endtask

  task byte_io(input [7:0] d, output [7:0] r8, output reg ack);
    int i;
    reg r;
  begin
    for (i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      r8[i] = r;
    end
    bit_io(1'b1, ack);
  end
  endtask

  task put(input [7:0] d);
    reg [7:0] r8;
    reg a;
  begin
    byte_io(d, r8, a);
    `CHK(a, 1'b0)
  end
  endtask

  task reg_wr(input [7:0] ofs, input [7:0] d);
  begin
    cond(1'b1);
    put({dev_addr, 1'b0});
    put(ofs);
    put(d);
    cond(1'b0);
  end
  endtask

  task reg_rd(input [7:0] ofs, output [7:0] r8);
    reg a;
  begin
    cond(1'b1);
    put({dev_addr, 1'b0});
    put(ofs);
    cond(1'b1);
    put({dev_addr, 1'b1});
    byte_io(8'hff, r8, a);
    cond(1'b0);
  end
  endtask

  // Start, poll busy, read the result pair
  task convert(input [1:0] src, input int lt);
    reg [7:0] lo;
    reg [7:0] hi;
    int m;
    int t;
  begin
    lat = lt;
    m = n_starts;
    reg_wr(8'h00, {5'h01, src, 1'b0});
    reg_rd(8'h00, lo);
    if (lt > 300)
    begin
      `CHK(lo[3], 1'b1)
      reg_wr(8'h00, {5'h01, src, 1'b0});
    end
    for (t = 0; t < 40 && lo[3] !== 1'b0; t++)
      reg_rd(8'h00, lo);
    `CHK(lo, {5'h00, src, 1'b0})
    `CHK(n_starts - m, 1)
    `CHK(conv_src, src)
    reg_rd(src[0] ? 8'h02 : 8'h06, lo);
    reg_rd(src[0] ? 8'h03 : 8'h07, hi);
    `CHK({hi, lo}, exp_pair(src, conv_val))
  end
  endtask

  task report_and_stop;
  begin
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    cyc(20);
    sys_rst <= 1'b0;
    cyc(4);
    for (j = 8'h00; j < 8'h04; j++)
    begin
      reg_rd(8'h0f + j, q);
      `CHK(q, 8'h00)
    end
    // Routing, bias and power settings, fixed power values first
    for (k = 0; k < 6; k++)
    begin
      lfsr = lfsr_next(lfsr);
      v[15:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      v[31:16] = lfsr;
      if (k < 2)
        v[31:24] = (k == 0) ? 8'hf0 : 8'h70;
      for (j = 8'h00; j < 8'h04; j++)
        reg_wr(8'h0f + j, v[8*j +: 8]);
      `CHK({ladder_to_tia_switch, ladder_to_potentiostat_switch}, v[5:4])
      `CHK(tia_bias_level, v[15:13])
      `CHK(potentiostat_bias_level, v[12:8])
      `CHK({tia_sensor_input_select, potentiostat_sensor_input_select}, v[22:21])
      `CHK({onward_signal_select, preamp_enable}, v[19:18])
      `CHK({bias_ladder_power, block_power_enable}, {v[31], v[31:24]})
      for (j = 8'h00; j < 8'h04; j++)
      begin
        reg_rd(8'h0f + j, q);
        `CHK(q, v[8*j +: 8])
      end
    end
    convert(2'h0, 2000);
    convert(2'h1, 2000);
    for (k = 0; k < 4; k++)
    begin
      lfsr = lfsr_next(lfsr);
      convert({1'b0, lfsr[0]}, 3 + lfsr[5:0]);
    end
    convert(2'h1, 3);
    // Read-only place ignores writes, unmapped place reads zero
    reg_wr(8'h03, 8'h5a);
    reg_rd(8'h03, q);
    `CHK(q, conv_val[15:8])
    reg_rd(8'h20, q);
    `CHK(q, 8'h00)
    // Unsupported source launches nothing
    n = n_starts;
    reg_wr(8'h00, 8'h0c);
    cyc(20);
    `CHK(n_starts - n, 0)
    // Continuous mode relaunches until a control write with bit 3 clear
    lat = 3;
    n = n_starts;
    reg_wr(8'h00, 8'h0b);
    cyc(40);
    `CHK(n_starts - n > 2, 1'b1)
    reg_wr(8'h00, 8'h03);
    cyc(20);
    n = n_starts;
    cyc(40);
    `CHK(n_starts - n, 0)
    reg_rd(8'h00, q);
    `CHK(q, 8'h03)
    report_and_stop;
  end

  // Watchdog against a hung bus or converter
  initial
  begin
    #300000;
    err_total++;
    report_and_stop;
  end
endmodule // afemc_top_tb_top
